// ===== logic/dsrc_pkg.sv
// Constants, register map and state codes for the drive stop reaction control
package dsrc_pkg;
   // ******************************************************************
   // Timing
   // ******************************************************************
   localparam int CLK_PERIOD_NS  = 100;
   localparam int RAMP_TICK_NS   = 1000000;
   localparam int RAMP_TICK_CYC  = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ******************************************************************
   // Register map (word index on the register port)
   // ******************************************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h01;
   localparam logic [7:0] REG_QS_CODE   = 8'h02;
   localparam logic [7:0] REG_SD_CODE   = 8'h03;
   localparam logic [7:0] REG_QS_RAMP   = 8'h04;
   localparam logic [7:0] REG_SPEED_REF = 8'h05;
   localparam logic [7:0] REG_SPEED_OUT = 8'h06;
   localparam logic [7:0] REG_SRC_BASE  = 8'h08;
   localparam int         NUM_SRC       = 4;

   // Control register fields
   localparam int CTRL_ENABLE   = 0;
   localparam int CTRL_QS_REQ   = 1;
   localparam int CTRL_HALT     = 2;
   localparam int CTRL_TORQUE   = 3;
   localparam int CTRL_SRC_LSB  = 4;
   localparam int CTRL_BRAKE_EN = 6;

   // Reset values
   localparam logic [3:0]  QS_CODE_RST   = 4'h2;
   localparam logic [3:0]  SD_CODE_RST   = 4'hF;
   localparam logic [31:0] QS_RAMP_RST   = 32'h0000_0BB8;
   localparam logic [31:0] SRC_RAMP_RST  = 32'h0000_03E8;
   localparam logic [6:0]  CTRL_RST      = 7'h00;

   // Option codes
   localparam logic [3:0] QS_CODE_RSVD_A = 4'h4;
   localparam logic [3:0] QS_CODE_RSVD_B = 4'h8;
   localparam logic [3:0] SD_FOLLOW_QS   = 4'hF;
   localparam logic [3:0] SD_POWER_OFF   = 4'h0;
   localparam logic [3:0] SD_SLOWDOWN    = 4'h1;

   typedef enum logic [2:0] {
      ST_READY    = 3'b011,
      ST_OPERATE  = 3'b101,
      ST_QSTOP    = 3'b111,
      ST_SHUTDOWN = 3'b010
   } dsrc_state_type;

   typedef enum logic [1:0] {
      SK_POWER_OFF = 2'b00,
      SK_SLOWDOWN  = 2'b01,
      SK_QS_RAMP   = 2'b10,
      SK_CUR_LIMIT = 2'b11
   } dsrc_stop_type;
endpackage

// ===== logic/dsrc_ramp.sv
// Speed ramp generator stepping once per ramp tick
`timescale 1ns/100ps
module dsrc_ramp #(
   parameter int TICK_CYCLES = dsrc_pkg::RAMP_TICK_CYC
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic signed [31:0] target,
   input  wire logic [31:0]        rate,
   input  wire logic               force_zero,
   output logic signed [31:0]      speed,
   output logic                    at_target
);
   import dsrc_pkg::*;

   typedef struct packed {
      logic signed [31:0] speed;
      logic [31:0]        tick_cnt;
   } dsrc_ramp_state_type;

   dsrc_ramp_state_type s_q;
   dsrc_ramp_state_type s_d;
   logic signed [32:0]  up;
   logic signed [32:0]  dn;

   always_comb begin
      s_d = s_q;
      up  = 33'(s_q.speed) + $signed({1'b0, rate});
      dn  = 33'(s_q.speed) - $signed({1'b0, rate});
      if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         s_d.tick_cnt = 32'h0000_0000;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
      end
      if (force_zero) begin
         s_d.speed = 32'sh0000_0000;
      end else if (s_q.tick_cnt == 32'h0000_0000) begin
         // Step clamps at the target so no overshoot through zero
         if (s_q.speed < target) begin
            s_d.speed = (up > 33'(target)) ? target : up[31:0];
         end else if (s_q.speed > target) begin
            s_d.speed = (dn < 33'(target)) ? target : dn[31:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign speed     = s_q.speed;
   assign at_target = (s_q.speed == target);
endmodule

// ===== logic/dsrc_top.sv
// Stop reaction sequencer with register port and per-source ramps
// Contract
// - Each reference source has its own acceleration and braking ramp.
// - Stops still run speed ramps while in torque control mode.
// - Quick-stop reaction defaults to quick-stop ramp at 3000 rev/min/s.
// - Quick-stop request enters quick-stop state; exit depends on request and code.
// - Code 0 switches power stage off at once; axis coasts.
// - Code 1 brakes on slowdown ramp, then power stage off.
// - Code 2 brakes on quick-stop ramp, then power stage off.
// - Code 3 zeroes speed setpoint, brakes at current limit, then power off.
// - Codes 5,6,7 brake like 1,2,3 and hold axis in quick-stop.
// - In quick-stop, dropping enable does nothing until request is cleared.
// - Shutdown reaction applies on operation-enabled to ready transition.
// - Shutdown code -1 performs the current quick-stop reaction; for codes 5,6,7 the code brakes like 1,2,3 and does not hold.
// - Shutdown code 0 switches power stage off at once.
// - Shutdown code 1 ramps to zero then engages holding brake if fitted.
// - Halt brakes on the normal slowdown ramp.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module dsrc_top #(
   parameter int TICK_CYCLES = dsrc_pkg::RAMP_TICK_CYC
) (
   input  wire logic                  CLK,
   input  wire logic                  SRST,
   input  wire logic [7:0]            ADDR,
   input  wire logic [31:0]           WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output logic [31:0]                RDATA,
   output logic                       POWER_STAGE_ON,
   output logic signed [31:0]         SPEED_CMD,
   output logic                       HOLD_STOPPED,
   output logic                       BRAKE_ENGAGE,
   output logic                       CURRENT_LIMIT_BRAKE,
   output logic                       TORQUE_MODE,
   output dsrc_pkg::dsrc_state_type   DRIVE_STATE
);
   import dsrc_pkg::*;

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      dsrc_state_type           state;
      dsrc_stop_type            kind;
      logic                     hold;
      logic                     brake;
      logic [6:0]               ctrl;
      logic [3:0]               qs_code;
      logic [3:0]               sd_code;
      logic [31:0]              qs_ramp;
      logic signed [31:0]       speed_ref;
      logic [NUM_SRC-1:0][31:0] accel;
      logic [NUM_SRC-1:0][31:0] decel;
      logic [31:0]              rdata;
   } dsrc_state_all_type;

   dsrc_state_all_type  s_q;
   dsrc_state_all_type  s_d;
   logic signed [31:0]  ramp_target;
   logic [31:0]         ramp_rate;
   logic                ramp_zero;
   logic signed [31:0]  speed;
   logic                at_zero;
   logic                enable;
   logic                qs_req;
   logic                halt;
   logic [1:0]          src;
   logic                braking;
   logic                power_on;
   logic [31:0]         status;
   logic [7:0]          src_idx;

   assign enable  = s_q.ctrl[CTRL_ENABLE];
   assign qs_req  = s_q.ctrl[CTRL_QS_REQ];
   assign halt    = s_q.ctrl[CTRL_HALT];
   assign src     = s_q.ctrl[CTRL_SRC_LSB +: 2];
   assign at_zero = (speed == 32'sh0000_0000);
   assign braking = (s_q.state == ST_QSTOP) || (s_q.state == ST_SHUTDOWN);
   assign src_idx = ADDR - REG_SRC_BASE;

   // ******************************************************************
   // Ramp selection
   // ******************************************************************
   always_comb begin
      ramp_target = 32'sh0000_0000;
      ramp_rate   = s_q.decel[src];
      ramp_zero   = 1'b0;
      if (s_q.state == ST_OPERATE) begin
         if (halt) begin
            ramp_rate = s_q.decel[src];
         end else begin
            ramp_target = s_q.speed_ref;
            // Accelerate away from zero, brake toward it
            if ((s_q.speed_ref >= 0) == (speed < s_q.speed_ref)) begin
               ramp_rate = s_q.accel[src];
            end
         end
      end else if (braking) begin
         // Same speed ramp whether or not torque mode is active
         case (s_q.kind)
            SK_SLOWDOWN:  ramp_rate = s_q.decel[src];
            SK_QS_RAMP:   ramp_rate = s_q.qs_ramp;
            SK_CUR_LIMIT: ramp_zero = 1'b1;
            default:      ramp_zero = 1'b1;
         endcase
      end else begin
         ramp_zero = 1'b1;
      end
   end

   dsrc_ramp #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_ramp (
      .clk        (CLK),
      .srst       (SRST),
      .target     (ramp_target),
      .rate       (ramp_rate),
      .force_zero (ramp_zero),
      .speed      (speed),
      .at_target  ()
   );

   // ******************************************************************
   // Sequencer and register file
   // ******************************************************************
   always_comb begin
      s_d       = s_q;
      s_d.rdata = 32'h0000_0000;
      if (WR) begin
         case (ADDR)
            REG_CTRL:      s_d.ctrl = WDATA[6:0];
            REG_QS_CODE: begin
               if (WDATA[3:0] != QS_CODE_RSVD_A && WDATA[3:0] != QS_CODE_RSVD_B
                   && WDATA[3:0] <= 4'h8) begin
                  s_d.qs_code = WDATA[3:0];
               end
            end
            REG_SD_CODE: begin
               if (WDATA[3:0] == SD_FOLLOW_QS || WDATA[3:0] == SD_POWER_OFF
                   || WDATA[3:0] == SD_SLOWDOWN) begin
                  s_d.sd_code = WDATA[3:0];
               end
            end
            REG_QS_RAMP:   s_d.qs_ramp = WDATA;
            REG_SPEED_REF: s_d.speed_ref = WDATA;
            default: begin
               if (ADDR >= REG_SRC_BASE && src_idx < 8'(2 * NUM_SRC)) begin
                  if (src_idx[0]) begin
                     s_d.decel[src_idx[2:1]] = WDATA;
                  end else begin
                     s_d.accel[src_idx[2:1]] = WDATA;
                  end
               end
            end
         endcase
      end
      if (RD) begin
         case (ADDR)
            REG_CTRL:      s_d.rdata = {25'h0000000, s_q.ctrl};
            REG_STATUS:    s_d.rdata = status;
            REG_QS_CODE:   s_d.rdata = {28'h0000000, s_q.qs_code};
            REG_SD_CODE:   s_d.rdata = {28'h0000000, s_q.sd_code};
            REG_QS_RAMP:   s_d.rdata = s_q.qs_ramp;
            REG_SPEED_REF: s_d.rdata = s_q.speed_ref;
            REG_SPEED_OUT: s_d.rdata = speed;
            default: begin
               if (ADDR >= REG_SRC_BASE && src_idx < 8'(2 * NUM_SRC)) begin
                  s_d.rdata = src_idx[0] ? s_q.decel[src_idx[2:1]]
                                         : s_q.accel[src_idx[2:1]];
               end
            end
         endcase
      end

      case (s_q.state)
         ST_READY: begin
            if (enable && !qs_req) begin
               s_d.state = ST_OPERATE;
               s_d.brake = 1'b0;
            end
         end
         ST_OPERATE: begin
            if (qs_req) begin
               s_d.state = ST_QSTOP;
               s_d.kind  = dsrc_stop_type'(s_q.qs_code[1:0]);
               s_d.hold  = s_q.qs_code[2];
            end else if (!enable) begin
               s_d.state = ST_SHUTDOWN;
               s_d.hold  = 1'b0;
               if (s_q.sd_code == SD_FOLLOW_QS) begin
                  s_d.kind = dsrc_stop_type'(s_q.qs_code[1:0]);
               end else if (s_q.sd_code == SD_SLOWDOWN) begin
                  s_d.kind = SK_SLOWDOWN;
               end else begin
                  s_d.kind = SK_POWER_OFF;
               end
            end
         end
         ST_QSTOP: begin
            // Enable is not looked at here; a holding stop releases only once the request is cleared, power-off kind at once, others at zero speed
            if (s_q.hold) begin
               if (!qs_req && at_zero) begin
                  s_d.state = ST_READY;
               end
            end else if (at_zero || s_q.kind == SK_POWER_OFF) begin
               s_d.state = ST_READY;
            end
         end
         ST_SHUTDOWN: begin
            if (at_zero || s_q.kind == SK_POWER_OFF) begin
               s_d.state = ST_READY;
               s_d.brake = s_q.ctrl[CTRL_BRAKE_EN] && s_q.kind == SK_SLOWDOWN
                           && s_q.sd_code == SD_SLOWDOWN;
            end
         end
         default: s_d.state = ST_READY;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_q.state     <= ST_READY;
         s_q.kind      <= SK_POWER_OFF;
         s_q.hold      <= 1'b0;
         s_q.brake     <= 1'b0;
         s_q.ctrl      <= CTRL_RST;
         s_q.qs_code   <= QS_CODE_RST;
         s_q.sd_code   <= SD_CODE_RST;
         s_q.qs_ramp   <= QS_RAMP_RST;
         s_q.speed_ref <= 32'sh0000_0000;
         s_q.accel     <= {NUM_SRC{SRC_RAMP_RST}};
         s_q.decel     <= {NUM_SRC{SRC_RAMP_RST}};
         s_q.rdata     <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   // Power stays on through ramp braking, drops at once for power-off kind
   assign power_on = (s_q.state == ST_OPERATE)
                     || (braking && s_q.kind != SK_POWER_OFF);
   assign status   = {23'h000000, at_zero, s_q.ctrl[CTRL_TORQUE], CURRENT_LIMIT_BRAKE,
                      s_q.brake, HOLD_STOPPED, power_on, s_q.state};

   assign RDATA               = s_q.rdata;
   assign POWER_STAGE_ON      = power_on;
   assign SPEED_CMD           = speed;
   assign HOLD_STOPPED        = (s_q.state == ST_QSTOP) && s_q.hold && at_zero;
   assign BRAKE_ENGAGE        = s_q.brake;
   assign CURRENT_LIMIT_BRAKE = braking && s_q.kind == SK_CUR_LIMIT && !at_zero;
   assign TORQUE_MODE         = (s_q.state == ST_OPERATE) && s_q.ctrl[CTRL_TORQUE];
   assign DRIVE_STATE         = s_q.state;

   // ******************************************************************
   // Assertions
   // ******************************************************************
   a_reset_qs_ramp: assert property (@(posedge CLK) $past(SRST) && !SRST |->
      s_q.qs_ramp == QS_RAMP_RST && s_q.qs_code == QS_CODE_RST)
      else $error("quick-stop defaults wrong after reset");

   a_reserved_refused: assert property (@(posedge CLK) disable iff (SRST)
      WR && ADDR == REG_QS_CODE && (WDATA[3:0] == 4'h4 || WDATA[3:0] == 4'h8)
      |=> s_q.qs_code == $past(s_q.qs_code))
      else $error("reserved quick-stop code accepted");

   a_qs_entry: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_OPERATE && qs_req |=> s_q.state == ST_QSTOP)
      else $error("quick-stop request not taken");

   a_power_stage_off_at_once: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_OPERATE && qs_req && s_q.qs_code == 4'h0
      |=> !POWER_STAGE_ON ##1 s_q.state == ST_READY)
      else $error("code 0 did not drop power stage");

   a_current_limit_brake_zero: assert property (@(posedge CLK) disable iff (SRST)
      braking && s_q.kind == SK_CUR_LIMIT |=> SPEED_CMD == 32'sh0000_0000)
      else $error("current limit brake left speed nonzero");

   a_hold_stays: assert property (@(posedge CLK) disable iff (SRST)
      HOLD_STOPPED && qs_req && !WR |=> HOLD_STOPPED && POWER_STAGE_ON)
      else $error("holding quick-stop left without clear");

   a_enable_ignored: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_QSTOP && s_q.hold && qs_req && !enable
      |=> s_q.state == ST_QSTOP)
      else $error("quick-stop left on enable drop");

   a_sd_follow: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_OPERATE && !qs_req && !enable && s_q.sd_code == SD_FOLLOW_QS
      |=> s_q.state == ST_SHUTDOWN && s_q.kind == $past(s_q.qs_code[1:0]))
      else $error("shutdown did not follow quick-stop code");

   a_sd_power_stage_off: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_OPERATE && !qs_req && !enable && s_q.sd_code == SD_POWER_OFF
      |=> !POWER_STAGE_ON)
      else $error("shutdown code 0 kept power on");

   a_sd_brake: assert property (@(posedge CLK) disable iff (SRST)
      s_q.state == ST_SHUTDOWN && s_q.sd_code == SD_SLOWDOWN && at_zero
      && s_q.ctrl[CTRL_BRAKE_EN] |=> BRAKE_ENGAGE && s_q.state == ST_READY)
      else $error("holding brake not engaged after shutdown");
endmodule

// ===== verification/dsrc_ctrl_model.sv
// Supervising controller model driving the register port of the stop control
`timescale 1ns/100ps
module dsrc_ctrl_model (
   input  wire logic clk,
   output logic [7:0]  addr,
   output logic [31:0] wdata,
   output logic        wr,
   output logic        rd
);
   initial begin
      addr  = 8'h00;
      wdata = 32'h0000_0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // Idle bus shows inverted values so stale data is never mistaken for live
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
   endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the drive stop reaction control
`timescale 1ns/100ps
module tb;
   import dsrc_pkg::*;
   localparam int TK = 4;
   logic               clk, srst, wr, rd, rd_seen;
   logic [7:0]         addr;
   logic [31:0]        wdata, rdata;
   logic               pwr, hold, brk, current_limit_brake, torq;
   logic signed [31:0] spd;
   dsrc_state_type     st;
   logic [31:0]        exp_q[$], msk_q[$];
   int                 err_total, num_checks, cyc, seed, ref_v, n;
   logic [3:0]         c;
   logic [3:0]         codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};

   dsrc_ctrl_model i_ctl (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   dsrc_top #(.TICK_CYCLES(TK)) i_dut (
      .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .POWER_STAGE_ON(pwr), .SPEED_CMD(spd), .HOLD_STOPPED(hold),
      .BRAKE_ENGAGE(brk), .CURRENT_LIMIT_BRAKE(current_limit_brake), .TORQUE_MODE(torq),
      .DRIVE_STATE(st));

   initial clk = 1'b0;
   always #50 clk = ~clk;

   // ******************************************************************
   // Checking and reporting
   // ******************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) check(rdata, 32'hFFFF_FFFF, "unexpected read");
         else check(rdata & msk_q.pop_front(), exp_q.pop_front(), "read data");
      end
      rd_seen <= rd;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end

   // ******************************************************************
   // Stimulus helpers
   // ******************************************************************
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      i_ctl.rd_reg(a);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input dsrc_state_type s);
      int k;
      k = 0;
      while (st !== s && k < 400) begin
         tick(1);
         k++;
      end
      check(st, s, "state reached");
   endtask
   task automatic spin_up(input logic [31:0] ctl);
      int k;
      i_ctl.wr_reg(REG_CTRL, ctl);
      wait_st(ST_OPERATE);
      k = 0;
      while (spd !== 32'(ref_v) && k < 400) begin
         tick(1);
         k++;
      end
      check(spd, 32'(ref_v), "speed at reference");
   endtask
   task automatic stop_n(output int k);
      k = 0;
      while (spd !== 32'sh0 && k < 3000) begin
         tick(1);
         k++;
      end
   endtask

   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial begin
      seed = 32'h4412c947;
      srst = 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rdc(REG_QS_CODE, 32'h0000_0002, 32'h0000_000F);
      rdc(REG_SD_CODE, 32'h0000_000F, 32'h0000_000F);
      rdc(REG_QS_RAMP, 32'h0000_0BB8, 32'hFFFF_FFFF);
      for (int i = 0; i < 2 * NUM_SRC; i++) begin
         rdc(REG_SRC_BASE + 8'(i), 32'h0000_03E8, 32'hFFFF_FFFF);
      end
      rdc(8'h07, 32'h0000_0000, 32'hFFFF_FFFF);
      i_ctl.wr_reg(REG_QS_CODE, 32'h0000_0004);
      i_ctl.wr_reg(REG_QS_CODE, 32'h0000_0008);
      i_ctl.wr_reg(REG_QS_CODE, 32'h0000_0009);
      rdc(REG_QS_CODE, 32'h0000_0002, 32'h0000_000F);
      i_ctl.wr_reg(REG_SD_CODE, 32'h0000_0002);
      rdc(REG_SD_CODE, 32'h0000_000F, 32'h0000_000F);
      // Slow decel on source 0 separates slowdown from quick-stop ramp timing
      i_ctl.wr_reg(REG_SRC_BASE + 8'h01, 32'h0000_01F4);
      rdc(REG_SRC_BASE + 8'h03, 32'h0000_03E8, 32'hFFFF_FFFF);
      rdc(REG_SRC_BASE + 8'h01, 32'h0000_01F4, 32'hFFFF_FFFF);
      $display("test registers done");

      foreach (codes[k]) begin
         c = codes[k];
         ref_v = 6000 + 3000 * ($unsigned($random(seed)) % 3);
         i_ctl.wr_reg(REG_QS_CODE, {28'h0, c});
         i_ctl.wr_reg(REG_SPEED_REF, 32'(ref_v));
         spin_up(32'h0000_0001);
         i_ctl.wr_reg(REG_CTRL, 32'h0000_0003);
         tick(1);
         check(st, ST_QSTOP, "entered quick-stop");
         // Speed is still at reference here, so the limit flag must be up for codes 3 and 7
         check(pwr, 32'(c[1:0] != 2'h0), "power during stop");
         check(current_limit_brake, 32'(c[1:0] == 2'h3), "current limit flag");
         stop_n(n);
         if (c[1:0] == 2'h0 || c[1:0] == 2'h3) begin
            check(32'(n <= 2), 32'h1, "immediate stop");
         end
         if (c[1:0] == 2'h1) begin
            check(32'(n >= (ref_v / 500 - 1) * TK), 32'h1, "slowdown ramp");
         end
         if (c[1:0] == 2'h2) begin
            check(32'(n <= (ref_v / 3000 + 3) * TK), 32'h1, "fast ramp");
         end
         tick(3);
         if (c < 4'h4) begin
            check({pwr, st}, {1'b0, ST_READY}, "stopped");
            i_ctl.wr_reg(REG_CTRL, 32'h0000_0000);
         end else begin
            check({pwr, hold, st}, {1'b1, 1'b1, ST_QSTOP}, "holding");
            rdc(REG_STATUS, 32'h0000_011F, 32'h0000_01FF);
            rdc(REG_SPEED_OUT, 32'h0000_0000, 32'hFFFF_FFFF);
            i_ctl.wr_reg(REG_CTRL, 32'h0000_0002);
            tick(6);
            check(st, ST_QSTOP, "enable drop ignored");
            i_ctl.wr_reg(REG_CTRL, 32'h0000_0000);
            wait_st(ST_READY);
         end
         $display("test quick-stop code %0d done", c);
      end

      ref_v = 6000;
      i_ctl.wr_reg(REG_SPEED_REF, 32'h0000_1770);
      i_ctl.wr_reg(REG_SD_CODE, 32'h0000_0000);
      spin_up(32'h0000_0001);
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0000);
      stop_n(n);
      check(32'(n <= 2), 32'h1, "shutdown coast");
      wait_st(ST_READY);
      check(pwr, 32'h0, "power off");
      i_ctl.wr_reg(REG_SD_CODE, 32'h0000_0001);
      spin_up(32'h0000_0049);
      check(torq, 32'h1, "torque mode");
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0048);
      stop_n(n);
      check(32'(n >= (ref_v / 500 - 1) * TK), 32'h1, "shutdown ramp");
      wait_st(ST_READY);
      check(brk, 32'h1, "brake engaged");
      i_ctl.wr_reg(REG_SD_CODE, 32'h0000_000F);
      i_ctl.wr_reg(REG_QS_CODE, 32'h0000_0002);
      spin_up(32'h0000_0001);
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0000);
      stop_n(n);
      check(32'(n <= (ref_v / 3000 + 3) * TK), 32'h1, "follows quick-stop");
      wait_st(ST_READY);
      $display("test shutdown done");

      spin_up(32'h0000_0001);
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0005);
      stop_n(n);
      check(32'(n >= (ref_v / 500 - 1) * TK), 32'h1, "halt ramp");
      check(st, ST_OPERATE, "halt keeps operating");
      // Source 1 keeps reset ramps, twice as steep as source 0 decel
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0011);
      tick(60);
      check(spd, 32'(ref_v), "halt released");
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0015);
      stop_n(n);
      check(32'(n <= (ref_v / 1000 + 1) * TK), 32'h1, "source 1 ramp");
      i_ctl.wr_reg(REG_CTRL, 32'h0000_0000);
      wait_st(ST_READY);
      $display("test halt done");
      tick(4);
      end_of_test;
   end
endmodule
